/* design/rie_defs.vh */
// Constants for the radio interrupt enable clear block
`ifndef RIE_DEFS_VH
`define RIE_DEFS_VH

`define RIE_ADDR_W 12
`define RIE_DATA_W 32

`define RIE_OFS_ENABLE 12'h300
`define RIE_OFS_SET 12'h304
`define RIE_OFS_CLEAR 12'h308
`define RIE_OFS_STATUS 12'h310

`define RIE_RESET_VAL 32'h00000000
`define RIE_IMPL_MASK 32'h1CFFC000

`define RIE_BIT_FRAME_BEGIN 14
`define RIE_BIT_ED_DONE 15
`define RIE_BIT_ED_HALTED 16
`define RIE_BIT_CH_CLEAR 17
`define RIE_BIT_CH_OCCUPIED 18
`define RIE_BIT_CH_HALTED 19
`define RIE_BIT_RATE_SWITCH 20
`define RIE_BIT_TX_PREPARED 21
`define RIE_BIT_RX_PREPARED 22
`define RIE_BIT_MAC_HIT 23
`define RIE_BIT_SYNC 26
`define RIE_BIT_PHY_DONE 27
`define RIE_BIT_TONE_SEEN 28

`define RIE_MODE_W 4
`define RIE_MODE_LONG_RANGE_SLOW 4'h4
`define RIE_MODE_LONG_RANGE_FAST 4'h5
`define RIE_MODE_LOWRATE_WPAN 4'h6

`define RIE_RESP_OKAY 2'h0
`define RIE_RESP_SLVERR 2'h2

`endif

/* design/rie_irq_enable.v */
// Radio interrupt enable store with set, clear and event status over AXI4-Lite
//
// The implementer's own choices: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/10ps
`include "rie_defs.vh"

module rie_irq_enable (
	input wire clk,
	input wire nrst,
	input wire [`RIE_ADDR_W-1:0] awaddr,
	input wire [2:0] awprot,
	input wire awvalid,
	output reg awready,
	input wire [`RIE_DATA_W-1:0] wdata,
	input wire [3:0] wstrb,
	input wire wvalid,
	output reg wready,
	output reg [1:0] bresp,
	output reg bvalid,
	input wire bready,
	input wire [`RIE_ADDR_W-1:0] araddr,
	input wire [2:0] arprot,
	input wire arvalid,
	output reg arready,
	output reg [`RIE_DATA_W-1:0] rdata,
	output reg [1:0] rresp,
	output reg rvalid,
	input wire rready,
	input wire frameBeginEvt,
	input wire energyDetectDoneEvt,
	input wire energyDetectHaltedEvt,
	input wire channelClearEvt,
	input wire channelOccupiedEvt,
	input wire channelAssessHaltedEvt,
	input wire codedRateSwitchEvt,
	input wire transmitPreparedEvt,
	input wire receivePreparedEvt,
	input wire macHeaderHitEvt,
	input wire phyFrameDoneEvt,
	input wire toneExtensionSeenEvt,
	input wire preambleSeen,
	input wire rxActive,
	input wire [`RIE_MODE_W-1:0] radioMode,
	output reg irq
);

	reg awHave;
	reg wHave;
	reg [`RIE_ADDR_W-1:0] awAddrQ;
	reg [`RIE_DATA_W-1:0] wDataQ;
	reg [3:0] wStrbQ;
	reg [`RIE_DATA_W-1:0] enable;
	reg [`RIE_DATA_W-1:0] status;
	reg next_awHave;
	reg next_wHave;
	reg next_rvalid;
	reg [`RIE_DATA_W-1:0] readMux;
	reg readHit;
	reg wHit;
	reg wrSet;
	reg wrClr;
	reg wrStat;
	reg syncMode;

	wire doWrite;
	wire [`RIE_ADDR_W-1:0] wAddrWord;
	wire [`RIE_ADDR_W-1:0] rAddrWord;
	wire [`RIE_DATA_W-1:0] strbMask;
	wire [`RIE_DATA_W-1:0] wOnes;
	wire [`RIE_DATA_W-1:0] evtVec;
	wire [`RIE_DATA_W-1:0] pending;
	wire syncEvt;

	// Only these bits hold state; the rest read as 0 and ignore writes
	localparam [`RIE_DATA_W-1:0] implBits = `RIE_IMPL_MASK;

	// Protection bits carry no meaning here; every access is allowed
	assign doWrite = awHave & wHave & ~bvalid;
	assign wAddrWord = {awAddrQ[`RIE_ADDR_W-1:2], 2'b00};
	assign rAddrWord = {araddr[`RIE_ADDR_W-1:2], 2'b00};

	// Only the enable store and status are written; enable view is read only
	always @* begin
		wrSet = 1'b0;
		wrClr = 1'b0;
		wrStat = 1'b0;
		wHit = 1'b1;
		case (wAddrWord)
			`RIE_OFS_ENABLE: begin
				// Accepted with OKAY so a probe of the view sees no error
				wHit = 1'b1;
			end
			`RIE_OFS_SET: begin
				wrSet = doWrite;
			end
			`RIE_OFS_CLEAR: begin
				wrClr = doWrite;
			end
			`RIE_OFS_STATUS: begin
				wrStat = doWrite;
			end
			default: begin
				wHit = 1'b0;
			end
		endcase
	end

	assign strbMask = {{8{wStrbQ[3]}}, {8{wStrbQ[2]}},
		{8{wStrbQ[1]}}, {8{wStrbQ[0]}}};
	// Bits written as 0 leave the store alone; lower event bits stay 0
	assign wOnes = wDataQ & strbMask & `RIE_IMPL_MASK;

	// A preamble hint outside a receive or outside these modes is ignored
	always @* begin
		case (radioMode)
			`RIE_MODE_LONG_RANGE_SLOW: begin
				syncMode = 1'b1;
			end
			`RIE_MODE_LONG_RANGE_FAST: begin
				syncMode = 1'b1;
			end
			`RIE_MODE_LOWRATE_WPAN: begin
				syncMode = 1'b1;
			end
			default: begin
				syncMode = 1'b0;
			end
		endcase
	end
	assign syncEvt = preambleSeen & rxActive & syncMode;

	assign evtVec[13:0] = 14'h0000;
	assign evtVec[`RIE_BIT_FRAME_BEGIN] = frameBeginEvt;
	assign evtVec[`RIE_BIT_ED_DONE] = energyDetectDoneEvt;
	assign evtVec[`RIE_BIT_ED_HALTED] = energyDetectHaltedEvt;
	assign evtVec[`RIE_BIT_CH_CLEAR] = channelClearEvt;
	assign evtVec[`RIE_BIT_CH_OCCUPIED] = channelOccupiedEvt;
	assign evtVec[`RIE_BIT_CH_HALTED] = channelAssessHaltedEvt;
	assign evtVec[`RIE_BIT_RATE_SWITCH] = codedRateSwitchEvt;
	assign evtVec[`RIE_BIT_TX_PREPARED] = transmitPreparedEvt;
	assign evtVec[`RIE_BIT_RX_PREPARED] = receivePreparedEvt;
	assign evtVec[`RIE_BIT_MAC_HIT] = macHeaderHitEvt;
	assign evtVec[25:24] = 2'h0;
	// No filtering of false preambles: software must expect stray syncs
	assign evtVec[`RIE_BIT_SYNC] = syncEvt;
	assign evtVec[`RIE_BIT_PHY_DONE] = phyFrameDoneEvt;
	assign evtVec[`RIE_BIT_TONE_SEEN] = toneExtensionSeenEvt;
	assign evtVec[31:29] = 3'h0;

	// Per bit enable and sticky status; one store for set and clear paths
	genvar i;
	generate
		for (i = 0; i < `RIE_DATA_W; i = i + 1) begin : gBit
			always @(posedge clk or negedge nrst) begin
				if (!nrst) begin
					enable[i] <= 1'b0;
				end else if (wrSet && wOnes[i]) begin
					enable[i] <= 1'b1;
				end else if (wrClr && wOnes[i]) begin
					enable[i] <= 1'b0;
				end
			end

			always @(posedge clk or negedge nrst) begin
				if (!nrst) begin
					status[i] <= 1'b0;
				end else if (evtVec[i] && implBits[i]) begin
					// An event in the clearing cycle is kept
					status[i] <= 1'b1;
				end else if (wrStat && wOnes[i]) begin
					status[i] <= 1'b0;
				end
			end
		end
	endgenerate

	// Only events both latched and enabled may request service
	assign pending = status & enable;

	// Registered so the pin is glitch free; lags status by one cycle
	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			irq <= 1'b0;
		end else begin
			irq <= |pending;
		end
	end

	always @* begin
		next_awHave = awHave;
		if (awvalid && awready) begin
			next_awHave = 1'b1;
		end
		if (doWrite) begin
			next_awHave = 1'b0;
		end
	end

	always @* begin
		next_wHave = wHave;
		if (wvalid && wready) begin
			next_wHave = 1'b1;
		end
		if (doWrite) begin
			next_wHave = 1'b0;
		end
	end

	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			awHave <= 1'b0;
			wHave <= 1'b0;
		end else begin
			awHave <= next_awHave;
			wHave <= next_wHave;
		end
	end

	// Ready drops once a beat is held, so no second beat can overwrite it
	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			awready <= 1'b0;
		end else begin
			awready <= ~next_awHave;
		end
	end

	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			wready <= 1'b0;
		end else begin
			wready <= ~next_wHave;
		end
	end

	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			awAddrQ <= {`RIE_ADDR_W{1'b0}};
		end else if (awvalid && awready) begin
			awAddrQ <= awaddr;
		end
	end

	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			wDataQ <= `RIE_RESET_VAL;
			wStrbQ <= 4'h0;
		end else if (wvalid && wready) begin
			wDataQ <= wdata;
			wStrbQ <= wstrb;
		end
	end

	// Response stands until taken; a held write waits for it to clear
	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			bvalid <= 1'b0;
		end else if (doWrite) begin
			bvalid <= 1'b1;
		end else if (bvalid && bready) begin
			bvalid <= 1'b0;
		end
	end

	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			bresp <= `RIE_RESP_OKAY;
		end else if (doWrite) begin
			bresp <= wHit ? `RIE_RESP_OKAY : `RIE_RESP_SLVERR;
		end
	end

	// Set and clear addresses both read back the same enable store
	always @* begin
		readMux = `RIE_RESET_VAL;
		readHit = 1'b1;
		case (rAddrWord)
			`RIE_OFS_ENABLE: begin
				readMux = enable;
			end
			`RIE_OFS_SET: begin
				readMux = enable;
			end
			`RIE_OFS_CLEAR: begin
				readMux = enable;
			end
			`RIE_OFS_STATUS: begin
				readMux = status;
			end
			default: begin
				readHit = 1'b0;
			end
		endcase
	end

	always @* begin
		next_rvalid = rvalid;
		if (arvalid && arready) begin
			next_rvalid = 1'b1;
		end else if (rvalid && rready) begin
			next_rvalid = 1'b0;
		end
	end

	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			rvalid <= 1'b0;
		end else begin
			rvalid <= next_rvalid;
		end
	end

	// One read at a time: the address is refused while data is waiting
	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			arready <= 1'b0;
		end else begin
			arready <= ~next_rvalid;
		end
	end

	// Data is captured once at the address edge and then held
	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			rdata <= `RIE_RESET_VAL;
			rresp <= `RIE_RESP_OKAY;
		end else if (arvalid && arready) begin
			rdata <= readMux;
			rresp <= readHit ? `RIE_RESP_OKAY : `RIE_RESP_SLVERR;
		end
	end

endmodule // rie_irq_enable

/* testbench/rie_irq_enable_props.sv */
// Bus handshake and interrupt checks for the enable clear block
`timescale 1ns/10ps
module rie_props (
	input wire clk,
	input wire nrst,
	input wire awvalid,
	input wire awready,
	input wire wvalid,
	input wire wready,
	input wire bvalid,
	input wire bready,
	input wire arvalid,
	input wire arready,
	input wire rvalid,
	input wire rready,
	input wire irq
);
	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);
	sequence wrTaken;
		awvalid && awready && wvalid && wready;
	endsequence
	sequence rdTaken;
		arvalid && arready;
	endsequence
	aw_refuse_a: assert property (awvalid && awready |=> !awready)
		else $error("aw not refused");
	w_refuse_a: assert property (wvalid && wready |=> !wready)
		else $error("w not refused");
	// Response two cycles after both beats are taken, set on the same edge the write takes effect
	wr_resp_a: assert property (wrTaken |=> ##1 bvalid)
		else $error("no write response");
	rd_resp_a: assert property (rdTaken |=> rvalid)
		else $error("no read data");
	ar_refuse_a: assert property (rdTaken |=> !arready)
		else $error("ar not refused");
	rd_block_a: assert property (rvalid |-> !arready)
		else $error("ar open during read");
	r_once_a: assert property (rvalid && rready |=> !rvalid)
		else $error("read data repeated");
	irq_reset_a: assert property ($rose(nrst) |-> !irq)
		else $error("irq high after reset");
endmodule // rie_props
bind rie_irq_enable rie_props propsInst (.clk, .nrst, .awvalid, .awready,
	.wvalid, .wready, .bvalid, .bready, .arvalid, .arready, .rvalid,
	.rready, .irq);

/* testbench/tb_top.sv */
// Self-checking bench for the radio interrupt enable clear block
`timescale 1ns/10ps
`include "rie_defs.vh"
module tb_top;
	logic clk, nrst, awvalid, wvalid, bready, arvalid, rready;
	logic preambleSeen, rxActive, sy;
	logic [11:0] awaddr, araddr, ev;
	logic [2:0] awprot, arprot;
	logic [3:0] wstrb, radioMode;
	logic [31:0] wdata, en, q, seed;
	logic [1:0] r;
	wire awready, wready, bvalid, arready, rvalid, irq;
	wire [1:0] bresp, rresp;
	wire [31:0] rdata;
	int errCount, checks;
	rie_irq_enable dut (.clk, .nrst, .awaddr, .awprot, .awvalid, .awready,
		.wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr,
		.arprot, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
		.frameBeginEvt(ev[0]), .energyDetectDoneEvt(ev[1]),
		.energyDetectHaltedEvt(ev[2]), .channelClearEvt(ev[3]),
		.channelOccupiedEvt(ev[4]), .channelAssessHaltedEvt(ev[5]),
		.codedRateSwitchEvt(ev[6]), .transmitPreparedEvt(ev[7]),
		.receivePreparedEvt(ev[8]), .macHeaderHitEvt(ev[9]),
		.phyFrameDoneEvt(ev[10]), .toneExtensionSeenEvt(ev[11]),
		.preambleSeen, .rxActive, .radioMode, .irq);
	function automatic logic [31:0] lfsr(logic [31:0] v);
		return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction
	// Gap in the map after the header hit bit
	function automatic int pos(int i);
		return i < 10 ? 14 + i : 17 + i;
	endfunction
	// Only strobed lanes of implemented bits take a written 1
	function automatic logic [31:0] expEn(logic [31:0] e, logic [31:0] w,
		logic [3:0] s, logic st);
		logic [31:0] m;
		m = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}} & w;
		m = m & `RIE_IMPL_MASK;
		return st ? e | m : e & ~m;
	endfunction
	function automatic logic syncExp(logic [3:0] md, logic rx);
		return rx && (md == `RIE_MODE_LONG_RANGE_SLOW ||
			md == `RIE_MODE_LONG_RANGE_FAST || md == `RIE_MODE_LOWRATE_WPAN);
	endfunction
	task automatic giveVerdict;
		$display("checks %0d errors %0d", checks, errCount);
		if (errCount == 0 && checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task automatic chk(string s, logic [31:0] e, logic [31:0] v);
		checks++;
		if (v !== e) begin
			errCount++;
			$display("[FAIL] %s exp %h got %h", s, e, v);
		end
	endtask
	task automatic wr(logic [11:0] a, logic [31:0] v);
		int n = 0;
		@(posedge clk);
		awaddr <= a;
		wdata <= v;
		awvalid <= 1;
		wvalid <= 1;
		do begin
			@(posedge clk);
			n++;
			if (awready) awvalid <= 0;
			if (wready) wvalid <= 0;
			r = bresp;
		end while (!bvalid && n < 50);
		if (!bvalid) begin
			errCount++;
			giveVerdict;
		end
	endtask
	task automatic rd(logic [11:0] a);
		int n = 0;
		@(posedge clk);
		araddr <= a;
		arvalid <= 1;
		do begin
			@(posedge clk);
			n++;
			if (arready) arvalid <= 0;
		end while (!rvalid && n < 50);
		q = rdata;
		r = rresp;
		if (!rvalid) begin
			errCount++;
			giveVerdict;
		end
	endtask
	initial begin
		clk = 0;
		forever #12.5 clk = ~clk;
	end
	initial begin
		{nrst, awvalid, wvalid, arvalid, preambleSeen, rxActive} <= 0;
		{awaddr, araddr, ev, radioMode, awprot, arprot, wdata} <= 0;
		{bready, rready, wstrb} <= 6'h3F;
		seed = 32'h4E658534;
		repeat (10) @(posedge clk);
		nrst <= 1;
		rd(`RIE_OFS_CLEAR);
		chk("reset", 0, q);
		wr(`RIE_OFS_SET, 32'hFFFFFFFF);
		wr(`RIE_OFS_ENABLE, 0);
		rd(`RIE_OFS_CLEAR);
		chk("shared", `RIE_IMPL_MASK, q);
		en = `RIE_IMPL_MASK;
		rd(12'h0FC);
		chk("rresp", `RIE_RESP_SLVERR, r);
		chk("rdata", 0, q);
		wr(12'h0FC, 0);
		chk("bresp", `RIE_RESP_SLVERR, r);
		// Zero bits of each word must leave their enables alone
		repeat (24) begin
			seed = lfsr(seed);
			wstrb <= seed[5:2];
			wr(seed[0] ? `RIE_OFS_SET : `RIE_OFS_CLEAR, seed);
			chk("bresp ok", `RIE_RESP_OKAY, r);
			en = expEn(en, seed, seed[5:2], seed[0]);
			rd(seed[1] ? `RIE_OFS_SET : `RIE_OFS_CLEAR);
			chk("enable", en, q);
			chk("rresp ok", `RIE_RESP_OKAY, r);
		end
		wstrb <= 4'hF;
		wr(`RIE_OFS_SET, 32'hFFFFFFFF);
		for (int i = 0; i < 12; i++) begin
			ev <= 12'h1 << i;
			@(posedge clk);
			ev <= 0;
			repeat (2) @(posedge clk);
			chk("irq on", 1, irq);
			rd(`RIE_OFS_STATUS);
			chk("status", 1 << pos(i), q);
			wr(`RIE_OFS_CLEAR, 1 << pos(i));
			repeat (2) @(posedge clk);
			chk("irq masked", 0, irq);
			wr(`RIE_OFS_SET, 32'hFFFFFFFF);
			wr(`RIE_OFS_STATUS, 32'hFFFFFFFF);
			repeat (2) @(posedge clk);
			chk("irq off", 0, irq);
		end
		// Event pulse lands on the clearing edge: the set must win
		fork
			wr(`RIE_OFS_STATUS, 32'hFFFFFFFF);
			begin
				repeat (2) @(posedge clk);
				ev <= 12'h001;
				@(posedge clk);
				ev <= 0;
			end
		join
		rd(`RIE_OFS_STATUS);
		chk("set wins", 1 << pos(0), q);
		wr(`RIE_OFS_STATUS, 32'hFFFFFFFF);
		rd(`RIE_OFS_STATUS);
		chk("cleared", 0, q);
		for (int m = 0; m < 32; m++) begin
			sy = syncExp(m[3:0], !m[4]);
			radioMode <= m[3:0];
			rxActive <= !m[4];
			preambleSeen <= 1;
			@(posedge clk);
			preambleSeen <= 0;
			repeat (2) @(posedge clk);
			chk("sync irq", sy, irq);
			rd(`RIE_OFS_STATUS);
			chk("sync", {31'h0, sy} << `RIE_BIT_SYNC, q);
			wr(`RIE_OFS_STATUS, q);
		end
		// Reset in mid-run must drop every enable and pending event
		ev <= 12'h001;
		@(posedge clk);
		ev <= 0;
		repeat (2) @(posedge clk);
		chk("irq before reset", 1, irq);
		nrst <= 0;
		@(posedge clk);
		chk("irq in reset", 0, irq);
		repeat (2) @(posedge clk);
		nrst <= 1;
		rd(`RIE_OFS_CLEAR);
		chk("enable reset", 0, q);
		rd(`RIE_OFS_STATUS);
		chk("status reset", 0, q);
		giveVerdict;
	end
endmodule // tb_top
